// File: src/msp_defines.vh
// Constants shared by the memory string printer design files
`ifndef MSP_DEFINES_VH
`define MSP_DEFINES_VH
// ==========================================
// Register offsets (byte addresses)
`define MSP_OFF_CTRL 8'h00
`define MSP_OFF_FLAGS 8'h04
`define MSP_OFF_PORT 8'h08
`define MSP_OFF_START 8'h0c
`define MSP_OFF_COUNT 8'h10
`define MSP_OFF_APPEND 8'h14
`define MSP_OFF_SWSTART 8'h18
`define MSP_OFF_SWCOUNT 8'h1c
`define MSP_OFF_LITADDR 8'h20
`define MSP_OFF_LITCHAR 8'h24
`define MSP_OFF_LITRES 8'h28
`define MSP_OFF_MADDR 8'h2c
`define MSP_OFF_MDATA 8'h30
`define MSP_OFF_ISTAT 8'h34
`define MSP_OFF_IMASK 8'h38
`define MSP_OFF_RELAY 8'h3c
// ==========================================
// Field positions
`define MSP_CTRL_EN 0
`define MSP_CTRL_SWAP 1
`define MSP_CTRL_SWTRIG 2
`define MSP_CTRL_LITBEGIN 3
`define MSP_CTRL_LITEND 4
`define MSP_CNT_ADDR_LSB 8
`define MSP_CNT_FROM_MEM 15
`define MSP_APP_N_LSB 16
`define MSP_LITRES_CODE_LSB 16
// ==========================================
// Interrupt status bits
`define MSP_IRQ_COMPLETE 0
`define MSP_IRQ_CANNOT 1
`define MSP_IRQ_INVALID 2
`define MSP_IRQ_PORTERR 3
`define MSP_IRQ_TEXTERR 4
`define MSP_IRQ_LITDONE 5
`define MSP_IRQ_SWAPDONE 6
`define MSP_IRQ_W 7
// ==========================================
// Values and limits
`define MSP_PORT_TWO 4'h2
`define MSP_MAX_BYTES 16'h0080
`define MSP_MAX_APPEND 2'h2
`define MSP_ERR_TEXT 16'h01f3
`define MSP_RESET_PORT 4'h2
// ==========================================
// Timing
`define MSP_CLOCK_HZ 20000000
`define MSP_BAUD_RATE 9600
`define MSP_CTS_WAIT_MS 100
// ==========================================
// Character codes
`define MSP_CH_QUOTE 8'h22
`define MSP_CH_DOLLAR 8'h24
`define MSP_CH_LF 8'h0a
`define MSP_CH_CR 8'h0d
`define MSP_CH_FF 8'h0c
`define MSP_CH_TAB 8'h09
`define MSP_CH_LOW 8'h20
`define MSP_CH_HIGH 8'h7e
`endif

// File: src/msp_literal_decoder.v
// Text literal decoder: quoted text with dollar escapes into bytes
`include "msp_defines.vh"
module msp_literal_decoder (
  // Clock and reset
  input wire i_clock,
  input wire i_reset,
  // Command character stream
  input wire i_begin,
  input wire i_finish,
  input wire i_char_valid,
  input wire [7:0] i_char,
  output wire o_ready,
  // Decoded bytes and result
  output reg o_byte_valid,
  output reg [7:0] o_byte,
  output reg [7:0] o_length,
  output reg o_done,
  output reg o_error
);
  localparam S_IDLE = 3'd0;
  localparam S_OPEN = 3'd1;
  localparam S_TEXT = 3'd2;
  localparam S_ESC = 3'd3;
  localparam S_HEX = 3'd4;
  localparam S_LF = 3'd5;
  localparam S_CLOSED = 3'd6;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [3:0] hex_hi_r;
  reg emit;
  reg fail;
  reg [7:0] emit_byte;

  // Hex digit value with a valid flag on top
  function [4:0] hex_val;
    input [7:0] c;
    begin
      if (c >= 8'h30 && c <= 8'h39)
        hex_val = {1'b1, c[3:0]};
      else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
        hex_val = {1'b1, c[3:0] + 4'h9};
      else
        hex_val = 5'h00;
    end
  endfunction

  wire [4:0] hv = hex_val(i_char);
  wire printable = (i_char >= `MSP_CH_LOW) && (i_char <= `MSP_CH_HIGH);
  // A pending line feed of CRLF blocks the stream for one cycle
  assign o_ready = (state_r != S_LF);

  // Next state and byte to emit
  always @*
  begin
    emit = 1'b0;
    fail = 1'b0;
    emit_byte = i_char;
    state_nxt = state_r;
    if (state_r == S_LF)
    begin
      emit = 1'b1;
      emit_byte = `MSP_CH_LF;
      state_nxt = S_TEXT;
    end
    else if (i_char_valid)
    begin
      case (state_r)
        S_OPEN:
          if (i_char == `MSP_CH_QUOTE)
            state_nxt = S_TEXT;
          else
            fail = 1'b1;
        S_TEXT:
          if (i_char == `MSP_CH_QUOTE)
            state_nxt = S_CLOSED;
          else if (i_char == `MSP_CH_DOLLAR)
            state_nxt = S_ESC;
          else if (printable)
            emit = 1'b1;
          else
            fail = 1'b1;
        S_ESC:
        begin
          state_nxt = S_TEXT;
          case (i_char)
            `MSP_CH_QUOTE, `MSP_CH_DOLLAR: emit = 1'b1;
            8'h4c, 8'h6c: begin emit = 1'b1; emit_byte = `MSP_CH_LF; end
            8'h50, 8'h70: begin emit = 1'b1; emit_byte = `MSP_CH_FF; end
            8'h52, 8'h72: begin emit = 1'b1; emit_byte = `MSP_CH_CR; end
            8'h54, 8'h74: begin emit = 1'b1; emit_byte = `MSP_CH_TAB; end
            8'h4e, 8'h6e:
            begin
              emit = 1'b1;
              emit_byte = `MSP_CH_CR;
              state_nxt = S_LF;
            end
            default:
              if (hv[4])
                state_nxt = S_HEX;
              else
                fail = 1'b1;
          endcase
        end
        S_HEX:
          if (hv[4])
          begin
            emit = 1'b1;
            emit_byte = {hex_hi_r, hv[3:0]};
            state_nxt = S_TEXT;
          end
          else
            fail = 1'b1;
        S_CLOSED: fail = 1'b1;
        default: state_nxt = state_r;
      endcase
    end
  end

  // State, length and result pulses
  always @(posedge i_clock)
  begin
    o_byte_valid <= 1'b0;
    o_done <= 1'b0;
    o_error <= 1'b0;
    if (i_reset)
    begin
      state_r <= S_IDLE;
      hex_hi_r <= 4'h0;
      o_byte <= 8'h00;
      o_length <= 8'h00;
    end
    else if (i_begin)
    begin
      state_r <= S_OPEN;
      o_length <= 8'h00;
    end
    else if (i_finish && state_r != S_IDLE && o_ready)
    begin
      o_done <= (state_r == S_CLOSED);
      o_error <= (state_r != S_CLOSED);
      state_r <= S_IDLE;
    end
    else if (fail || (emit && {8'h00, o_length} == `MSP_MAX_BYTES))
    begin
      o_error <= 1'b1;
      state_r <= S_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == S_ESC)
        hex_hi_r <= hv[3:0];
      if (emit)
      begin
        o_byte_valid <= 1'b1;
        o_byte <= emit_byte;
        o_length <= o_length + 8'h01;
      end
    end
  end
endmodule // msp_literal_decoder

// File: src/msp_printer.v
// Memory string printer top: registers, word memory, swapper, serial port
// Functional notes
// - An empty quoted literal builds a string of zero characters.
// - Dollar then quote gives one quote character and does not close.
// - Bad text or missing quotes rejects the literal with code 499.
// - A trigger sends the byte count from consecutive words at start.
// - Configured append characters follow the data bytes of every string.
// - Byte swap exchanges high and low bytes while sending, memory untouched.
// - Busy stays high for the whole transmission.
// - Complete sets after the last byte, clears when the enable drops.
// - Cannot-execute flag rises when a print or swap cannot run.
// - Invalid-value flag rises when an operand is out of range.
// - Port-active flag is high while port two is sending.
// - Port-error flag rises on a communication error on port two.
// - The swapper exchanges bytes in place over 1 to 128 bytes.
// - Dollar and two hex digits give one byte of that code.
`include "msp_defines.vh"
module msp_printer #(
  parameter MEM_WORDS = 64,
  parameter AW = 6,
  parameter BIT_CYCLES = `MSP_CLOCK_HZ / `MSP_BAUD_RATE,
  parameter CTS_WAIT_CYCLES = `MSP_CTS_WAIT_MS * (`MSP_CLOCK_HZ / 1000)
) (
  // Clock and reset
  input wire i_clock,
  input wire i_reset,
  // Register port
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_write,
  input wire i_read,
  output reg [31:0] o_rdata,
  // Serial port two
  output wire o_txd,
  input wire i_cts_n,
  // Status outputs
  output reg o_busy,
  output reg o_complete,
  output reg o_cannot_execute_flag,
  output reg o_invalid_value_flag,
  output wire o_port_active_flag,
  output reg o_port_error_flag,
  output wire o_irq
);
  localparam P_IDLE = 2'd0;
  localparam P_RUN = 2'd1;
  localparam P_DONE = 2'd2;
  localparam [31:0] BIT_LAST = BIT_CYCLES - 1;
  localparam [31:0] WAIT_LAST = CTS_WAIT_CYCLES - 1;
  localparam [31:0] MEM_LIMIT = MEM_WORDS;

  // ==========================================
  // Storage and registers
  reg [15:0] mem_r [0:MEM_WORDS-1];
  reg ctrl_en_r, en_prev_r, ctrl_swap_r;
  reg [3:0] port_r;
  reg [AW-1:0] start_r, sw_start_r, lit_addr_r, maddr_r;
  reg [15:0] count_r;
  reg [17:0] append_r;
  reg [7:0] sw_count_r;
  reg [21:0] relay_r;
  reg [`MSP_IRQ_W-1:0] istat_r, imask_r;
  reg [15:0] lit_code_r;
  reg cts_meta_r, cts_sync_r;
  reg [1:0] p_state_r;
  reg [8:0] p_idx_r, p_total_r;
  reg [7:0] p_count_r;
  reg [AW-1:0] p_word_r;
  reg p_swap_r;
  reg [31:0] wait_r;
  reg tx_busy_r;
  reg [9:0] tx_shift_r;
  reg [3:0] tx_bits_r;
  reg [15:0] tx_baud_r;
  reg sw_busy_r;
  reg [AW-1:0] sw_addr_r, lit_word_r;
  reg [7:0] sw_left_r;
  reg lit_active_r, lit_pos_r;
  reg [31:0] rd_mux;

  // ==========================================
  // Request decode
  wire wr_ctrl = i_write && (i_addr == `MSP_OFF_CTRL);
  wire sw_req = wr_ctrl && i_wdata[`MSP_CTRL_SWTRIG];
  wire lb_req = wr_ctrl && i_wdata[`MSP_CTRL_LITBEGIN];
  wire le_req = wr_ctrl && i_wdata[`MSP_CTRL_LITEND];
  wire lc_req = i_write && (i_addr == `MSP_OFF_LITCHAR);
  wire md_wr = i_write && (i_addr == `MSP_OFF_MDATA);
  wire lit_ready, lit_bv, lit_done, lit_err;
  wire [7:0] lit_byte, lit_len;

  // ==========================================
  // Operand checks and acceptance
  wire [15:0] cnt_mem = mem_r[count_r[`MSP_CNT_ADDR_LSB +: AW]];
  wire [15:0] eff_cnt = count_r[`MSP_CNT_FROM_MEM] ? cnt_mem : {8'h00, count_r[7:0]};
  wire [1:0] app_n = append_r[`MSP_APP_N_LSB +: 2];
  wire [15:0] p_end = {{(16-AW){1'b0}}, start_r} + ((eff_cnt + 16'h0001) >> 1);
  wire [15:0] s_end = {{(16-AW){1'b0}}, sw_start_r} + {8'h00, (sw_count_r >> 1)}
    + {15'h0000, sw_count_r[0]};
  wire print_busy = (p_state_r == P_RUN);
  wire p_try = ctrl_en_r && !en_prev_r;
  wire p_cant = print_busy || sw_busy_r || lit_active_r;
  wire p_inval = (port_r != `MSP_PORT_TWO) || (eff_cnt == 16'h0000)
    || (eff_cnt > `MSP_MAX_BYTES) || (p_end > MEM_LIMIT[15:0]) || (app_n > `MSP_MAX_APPEND);
  wire p_go = p_try && !p_cant && !p_inval;
  wire s_cant = print_busy || sw_busy_r || lit_active_r || p_go;
  wire s_inval = (sw_count_r == 8'h00) || ({8'h00, sw_count_r} > `MSP_MAX_BYTES)
    || (s_end > MEM_LIMIT[15:0]);
  wire s_go = sw_req && !s_cant && !s_inval;
  wire l_cant = print_busy || sw_busy_r || p_go || s_go;
  wire l_go = lb_req && !l_cant;
  wire lit_refused = (lc_req || le_req) && !lit_ready;
  wire cannot_ev = (p_try && p_cant) || (sw_req && s_cant) || (lb_req && l_cant)
    || lit_refused;
  wire invalid_ev = (p_try && !p_cant && p_inval) || (sw_req && !s_cant && s_inval);
  wire any_go = p_go || s_go || l_go;

  // ==========================================
  // Byte selection for the transmitter
  wire [15:0] p_src = mem_r[p_word_r];
  wire p_in_data = (p_idx_r < {1'b0, p_count_r});
  wire p_take_hi = (~p_idx_r[0]) ^ p_swap_r;
  wire [8:0] app_idx = p_idx_r - {1'b0, p_count_r};
  wire [7:0] app_byte = app_idx[0] ? append_r[15:8] : append_r[7:0];
  wire [7:0] p_byte = p_in_data ? (p_take_hi ? p_src[15:8] : p_src[7:0]) : app_byte;
  wire p_more = (p_idx_r != p_total_r);
  wire tx_load = print_busy && !tx_busy_r && p_more && !cts_sync_r;
  wire p_stall = print_busy && !tx_busy_r && p_more && cts_sync_r;
  wire p_finish = print_busy && !tx_busy_r && !p_more;
  wire port_err_ev = p_stall && (wait_r == WAIT_LAST);
  wire [`MSP_IRQ_W-1:0] events = {s_go ? 1'b0 : (sw_busy_r && sw_left_r == 8'h01),
    lit_done, lit_err, port_err_ev, invalid_ev, cannot_ev, p_finish};

  assign o_txd = tx_shift_r[0];
  assign o_port_active_flag = tx_busy_r;
  assign o_irq = |(istat_r & imask_r);

  // Clear-to-send pin synchroniser
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      cts_meta_r <= 1'b1;
      cts_sync_r <= 1'b1;
    end
    else
    begin
      cts_meta_r <= i_cts_n;
      cts_sync_r <= cts_meta_r;
    end
  end

  // Software-written registers
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      ctrl_en_r <= 1'b0;
      ctrl_swap_r <= 1'b0;
      port_r <= `MSP_RESET_PORT;
      start_r <= {AW{1'b0}};
      count_r <= 16'h0000;
      append_r <= 18'h00000;
      sw_start_r <= {AW{1'b0}};
      sw_count_r <= 8'h00;
      lit_addr_r <= {AW{1'b0}};
      maddr_r <= {AW{1'b0}};
      imask_r <= {`MSP_IRQ_W{1'b0}};
      relay_r <= 22'h000000;
    end
    else if (i_write)
    begin
      case (i_addr)
        `MSP_OFF_CTRL:
        begin
          ctrl_en_r <= i_wdata[`MSP_CTRL_EN];
          ctrl_swap_r <= i_wdata[`MSP_CTRL_SWAP];
        end
        `MSP_OFF_PORT: port_r <= i_wdata[3:0];
        `MSP_OFF_START: start_r <= i_wdata[AW-1:0];
        `MSP_OFF_COUNT: count_r <= i_wdata[15:0];
        `MSP_OFF_APPEND: append_r <= i_wdata[17:0];
        `MSP_OFF_SWSTART: sw_start_r <= i_wdata[AW-1:0];
        `MSP_OFF_SWCOUNT: sw_count_r <= i_wdata[7:0];
        `MSP_OFF_LITADDR: lit_addr_r <= i_wdata[AW-1:0];
        `MSP_OFF_MADDR: maddr_r <= i_wdata[AW-1:0];
        `MSP_OFF_IMASK: imask_r <= i_wdata[`MSP_IRQ_W-1:0];
        `MSP_OFF_RELAY: relay_r <= i_wdata[21:0];
        default: maddr_r <= maddr_r;
      endcase
    end
  end

  // Sticky flags and interrupt status; a new event beats the clear
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      istat_r <= {`MSP_IRQ_W{1'b0}};
      o_cannot_execute_flag <= 1'b0;
      o_invalid_value_flag <= 1'b0;
      o_port_error_flag <= 1'b0;
      lit_code_r <= 16'h0000;
      en_prev_r <= 1'b0;
    end
    else
    begin
      en_prev_r <= ctrl_en_r;
      istat_r <= (istat_r & ~((i_write && i_addr == `MSP_OFF_ISTAT) ?
        i_wdata[`MSP_IRQ_W-1:0] : {`MSP_IRQ_W{1'b0}})) | events;
      o_cannot_execute_flag <= cannot_ev || (o_cannot_execute_flag && !any_go);
      o_invalid_value_flag <= invalid_ev || (o_invalid_value_flag && !any_go);
      o_port_error_flag <= port_err_ev || (o_port_error_flag && !p_go);
      if (lit_err)
        lit_code_r <= `MSP_ERR_TEXT;
      else if (l_go)
        lit_code_r <= 16'h0000;
    end
  end

  // Print sequencer: data bytes, then append characters
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      p_state_r <= P_IDLE;
      p_idx_r <= 9'h000;
      p_total_r <= 9'h000;
      p_count_r <= 8'h00;
      p_word_r <= {AW{1'b0}};
      p_swap_r <= 1'b0;
      wait_r <= 32'h00000000;
      o_busy <= 1'b0;
      o_complete <= 1'b0;
    end
    else
    begin
      case (p_state_r)
        P_IDLE:
          if (p_go)
          begin
            p_state_r <= P_RUN;
            o_busy <= 1'b1;
            o_complete <= 1'b0;
            p_idx_r <= 9'h000;
            p_count_r <= eff_cnt[7:0];
            p_total_r <= eff_cnt[8:0] + {7'h00, app_n};
            p_word_r <= start_r;
            p_swap_r <= ctrl_swap_r;
            wait_r <= 32'h00000000;
          end
        P_RUN:
          if (p_finish)
          begin
            p_state_r <= P_DONE;
            o_busy <= 1'b0;
            o_complete <= 1'b1;
          end
          else if (tx_load)
          begin
            p_idx_r <= p_idx_r + 9'h001;
            wait_r <= 32'h00000000;
            if (p_in_data && p_idx_r[0])
              p_word_r <= p_word_r + {{(AW-1){1'b0}}, 1'b1};
          end
          else if (port_err_ev)
          begin
            p_state_r <= P_IDLE;
            o_busy <= 1'b0;
          end
          else if (p_stall)
            wait_r <= wait_r + 32'h00000001;
        P_DONE:
          if (!ctrl_en_r)
          begin
            p_state_r <= P_IDLE;
            o_complete <= 1'b0;
          end
        default: p_state_r <= P_IDLE;
      endcase
    end
  end

  // Serial transmitter, 8 data bits, one stop bit, line idles high
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      tx_busy_r <= 1'b0;
      tx_shift_r <= 10'h3ff;
      tx_bits_r <= 4'h0;
      tx_baud_r <= 16'h0000;
    end
    else if (tx_load)
    begin
      tx_busy_r <= 1'b1;
      tx_shift_r <= {1'b1, p_byte, 1'b0};
      tx_bits_r <= 4'h0;
      tx_baud_r <= 16'h0000;
    end
    else if (tx_busy_r)
    begin
      if (tx_baud_r == BIT_LAST[15:0])
      begin
        tx_baud_r <= 16'h0000;
        tx_shift_r <= {1'b1, tx_shift_r[9:1]};
        tx_bits_r <= tx_bits_r + 4'h1;
        if (tx_bits_r == 4'h9)
          tx_busy_r <= 1'b0;
      end
      else
        tx_baud_r <= tx_baud_r + 16'h0001;
    end
  end

  // Swapper and literal packing pointers
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      sw_busy_r <= 1'b0;
      sw_addr_r <= {AW{1'b0}};
      sw_left_r <= 8'h00;
      lit_active_r <= 1'b0;
      lit_word_r <= {AW{1'b0}};
      lit_pos_r <= 1'b0;
    end
    else
    begin
      if (s_go)
      begin
        sw_busy_r <= 1'b1;
        sw_addr_r <= sw_start_r;
        sw_left_r <= (sw_count_r >> 1) + {7'h00, sw_count_r[0]};
      end
      else if (sw_busy_r)
      begin
        sw_addr_r <= sw_addr_r + {{(AW-1){1'b0}}, 1'b1};
        sw_left_r <= sw_left_r - 8'h01;
        if (sw_left_r == 8'h01)
          sw_busy_r <= 1'b0;
      end
      if (l_go)
      begin
        lit_active_r <= 1'b1;
        lit_word_r <= lit_addr_r;
        lit_pos_r <= 1'b0;
      end
      else
      begin
        if (lit_done || lit_err)
          lit_active_r <= 1'b0;
        if (lit_bv)
        begin
          lit_pos_r <= ~lit_pos_r;
          if (lit_pos_r)
            lit_word_r <= lit_word_r + {{(AW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // Word memory writes: swapper, then literal bytes, then software
  always @(posedge i_clock)
  begin
    if (sw_busy_r)
      mem_r[sw_addr_r] <= {mem_r[sw_addr_r][7:0], mem_r[sw_addr_r][15:8]};
    else if (lit_bv && !lit_pos_r)
      mem_r[lit_word_r][15:8] <= lit_byte;
    else if (lit_bv)
      mem_r[lit_word_r][7:0] <= lit_byte;
    else if (md_wr)
      mem_r[maddr_r] <= i_wdata[15:0];
  end

  // Read multiplexer
  always @*
  begin
    case (i_addr)
      `MSP_OFF_CTRL: rd_mux = {30'h00000000, ctrl_swap_r, ctrl_en_r};
      `MSP_OFF_FLAGS: rd_mux = {26'h0000000, o_port_error_flag, o_port_active_flag,
        o_invalid_value_flag, o_cannot_execute_flag, o_complete, o_busy};
      `MSP_OFF_PORT: rd_mux = {28'h0000000, port_r};
      `MSP_OFF_START: rd_mux = {{(32-AW){1'b0}}, start_r};
      `MSP_OFF_COUNT: rd_mux = {16'h0000, count_r};
      `MSP_OFF_APPEND: rd_mux = {14'h0000, append_r};
      `MSP_OFF_SWSTART: rd_mux = {{(32-AW){1'b0}}, sw_start_r};
      `MSP_OFF_SWCOUNT: rd_mux = {24'h000000, sw_count_r};
      `MSP_OFF_LITADDR: rd_mux = {{(32-AW){1'b0}}, lit_addr_r};
      `MSP_OFF_LITRES: rd_mux = {lit_code_r, 7'h00, lit_active_r, lit_len};
      `MSP_OFF_MADDR: rd_mux = {{(32-AW){1'b0}}, maddr_r};
      `MSP_OFF_MDATA: rd_mux = {16'h0000, mem_r[maddr_r]};
      `MSP_OFF_ISTAT: rd_mux = {{(32-`MSP_IRQ_W){1'b0}}, istat_r};
      `MSP_OFF_IMASK: rd_mux = {{(32-`MSP_IRQ_W){1'b0}}, imask_r};
      `MSP_OFF_RELAY: rd_mux = {10'h000, relay_r};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Read data stands only in the cycle after the read strobe
  always @(posedge i_clock)
  begin
    if (i_reset)
      o_rdata <= 32'h00000000;
    else
      o_rdata <= i_read ? rd_mux : 32'h00000000;
  end

  // Text literal decoder
  msp_literal_decoder u_literal (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_begin(l_go),
    .i_finish(le_req && lit_ready),
    .i_char_valid(lc_req && lit_ready),
    .i_char(i_wdata[7:0]),
    .o_ready(lit_ready),
    .o_byte_valid(lit_bv),
    .o_byte(lit_byte),
    .o_length(lit_len),
    .o_done(lit_done),
    .o_error(lit_err)
  );
endmodule // msp_printer

// File: tb/msp_props.sv
// Port-level timing checker for the memory string printer
module msp_props (
  // Watched ports
  input wire i_clock,
  input wire i_reset,
  input wire i_read,
  input wire [31:0] o_rdata,
  input wire o_txd,
  input wire o_busy,
  input wire o_complete,
  input wire o_cannot_execute_flag,
  input wire o_invalid_value_flag,
  input wire o_port_active_flag,
  input wire o_port_error_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  // ==========================================
  // Assertions; the bit width check assumes four clocks per bit
  chk_rdata_quiet: assert property (!$past(i_read) |-> o_rdata == 32'h0)
    else $error("read data outside read slot");
  chk_idle_line: assert property (!o_busy |-> o_txd)
    else $error("line active while not busy");
  chk_active_busy: assert property (o_port_active_flag |-> o_busy)
    else $error("port active without busy");
  chk_start_busy: assert property ($fell(o_txd) |-> o_busy)
    else $error("bit sent outside a print");
  chk_bit_width: assert property ($fell(o_txd) |-> (!o_txd) [*4])
    else $error("low bit shorter than a bit time");
  chk_done_ends: assert property ($rose(o_complete) |-> $fell(o_busy) && o_txd)
    else $error("complete without end of busy");
  chk_busy_clear: assert property (o_busy |-> !o_complete)
    else $error("complete during busy");
  chk_error_abort: assert property (
    $rose(o_port_error_flag) |-> ##[0:1] (!o_busy && !o_complete))
    else $error("port error without abort");
  // Main scenarios
  cov_done: cover property ($rose(o_complete));
  cov_perr: cover property ($rose(o_port_error_flag));
  cov_inval: cover property ($rose(o_invalid_value_flag));
  cov_cannot: cover property ($rose(o_cannot_execute_flag));
endmodule // msp_props

bind msp_printer msp_props i_msp_props (
  .i_clock(i_clock), .i_reset(i_reset), .i_read(i_read), .o_rdata(o_rdata),
  .o_txd(o_txd), .o_busy(o_busy), .o_complete(o_complete),
  .o_cannot_execute_flag(o_cannot_execute_flag),
  .o_invalid_value_flag(o_invalid_value_flag),
  .o_port_active_flag(o_port_active_flag), .o_port_error_flag(o_port_error_flag)
);

// File: tb/msp_rx_model.sv
// Receiving serial device: 8N1 capture and clear-to-send gate
module msp_rx_model #(
  parameter int BITC = 4
) (
  input wire logic i_clock,
  input wire logic i_txd,
  input wire logic i_hold,
  output logic o_cts_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic [7:0] sh;
  // Device refuses data while told to hold
  assign o_cts_n = i_hold;
  // Mid-bit sampling, lsb first; a bad stop bit stores an unknown byte
  always
  begin
    @(negedge i_txd);
    repeat (BITC / 2) @(posedge i_clock);
    for (int b = 0; b < 8; b++)
    begin
      repeat (BITC) @(posedge i_clock);
      sh[b] = i_txd;
    end
    repeat (BITC) @(posedge i_clock);
    got.push_back(i_txd === 1'b1 ? sh : 8'hxx);
  end
endmodule // msp_rx_model

// File: tb/msp_printer_test.sv
// Self-checking bench for the memory string printer
module msp_printer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock = 0, i_reset = 1, i_write = 0, i_read = 0, hold = 0;
  logic [7:0] i_addr = 0;
  logic [31:0] i_wdata = 0, rv, seed = 32'hc472;
  logic [15:0] mem [64];
  wire [31:0] o_rdata;
  wire txd, cts_n, busy, done, cef, ivf, paf, pef, irq;
  int mismatches = 0, cmp_count = 0;
  int st[5] = '{20, 20, 21, 0, 30};
  int cs[5] = '{5, 4, 3, 128, 'ha800};
  int ns[5] = '{5, 4, 3, 128, 7};
  int na[5] = '{2, 0, 1, 0, 0};
  logic [4:0] sws = 5'h06;
  int bp[5] = '{3, 2, 2, 2, 2};
  int bc[5] = '{4, 0, 129, 4, 8};
  int ba[5] = '{0, 0, 0, 'h30000, 0};
  int bs[5] = '{0, 0, 0, 0, 62};
  msp_printer #(.BIT_CYCLES(4), .CTS_WAIT_CYCLES(50)) i_msp_printer (
    .i_clock(i_clock), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .o_txd(txd), .i_cts_n(cts_n),
    .o_busy(busy), .o_complete(done), .o_cannot_execute_flag(cef),
    .o_invalid_value_flag(ivf), .o_port_active_flag(paf), .o_port_error_flag(pef),
    .o_irq(irq));
  msp_rx_model #(.BITC(4)) i_msp_rx_model (.i_clock(i_clock), .i_txd(txd), .i_hold(hold),
    .o_cts_n(cts_n));
  // ==========================================
  // Clock and helpers
  always #25 i_clock = ~i_clock;
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  function automatic logic [7:0] exp_byte(int s, int k, logic sw);
    logic [15:0] w;
    w = mem[s + k / 2];
    return ((k % 2 == 0) ^ sw) ? w[15:8] : w[7:0];
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Register bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_write <= 1'b1;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clock);
    i_addr <= a;
    i_read <= 1'b1;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1 v = o_rdata;
  endtask
  // Configure a print, raise enable, optionally wait for its end
  task automatic run(input int s, input int c, input int a, input logic sw, input logic w);
    wr(8'h0c, s);
    wr(8'h10, c);
    wr(8'h14, a);
    wr(8'h00, 32'h0);
    wr(8'h00, {30'h0, sw, 1'b1});
    repeat (3) @(posedge i_clock);
    for (int n = 0; w && n < 9000 && !done && !pef && !ivf && !cef; n++)
      @(posedge i_clock);
    repeat (2) @(posedge i_clock);
    #1;
  endtask
  task automatic expect_bytes(input int s, input int n, input logic sw, input int a);
    chk(i_msp_rx_model.got.size(), n + a);
    for (int k = 0; k < n + a && k < i_msp_rx_model.got.size(); k++)
      chk(i_msp_rx_model.got[k], k < n ? exp_byte(s, k, sw) : (k == n ? 8'h0d : 8'h0a));
    i_msp_rx_model.got.delete();
  endtask
  task automatic lit(input string s, input logic [7:0] n, input logic [15:0] code);
    wr(8'h00, 32'h8);
    foreach (s[i]) wr(8'h24, {24'h0, s[i]});
    wr(8'h00, 32'h10);
    rd(8'h28, rv);
    chk(rv[31:16], code);
    if (code == 16'h0) chk(rv[7:0], n);
  endtask
  // Watchdog
  initial
  begin
    repeat (60000) @(posedge i_clock);
    mismatches++;
    give_verdict();
  end
  // Main sequence
  initial
  begin
    repeat (12) @(posedge i_clock);
    i_reset <= 1'b0;
    rd(8'h08, rv);
    chk(rv, 32'h2);
    rd(8'h40, rv);
    chk(rv, 32'h0);
    wr(8'h3c, 32'h3fffff);
    rd(8'h3c, rv);
    chk(rv, 32'h3fffff);
    for (int a = 0; a < 64; a++)
    begin
      mem[a] = (a == 40) ? 16'h0007 : rnd();
      wr(8'h2c, a);
      wr(8'h30, {16'h0, mem[a]});
    end
    for (int i = 0; i < 5; i++)
    begin
      run(st[i], cs[i], na[i] << 16 | 'h0a0d, sws[i], 1'b1);
      chk(done, 1'b1);
      expect_bytes(st[i], ns[i], sws[i], na[i]);
    end
    wr(8'h2c, 32'd20);
    rd(8'h30, rv);
    chk(rv, {16'h0, mem[20]});
    wr(8'h38, 32'h1);
    #1 chk(irq, 1'b1);
    wr(8'h34, 32'h7f);
    #1 chk(irq, 1'b0);
    wr(8'h00, 32'h0);
    @(posedge i_clock);
    #1 chk(done, 1'b0);
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h08, bp[i]);
      run(bs[i], bc[i], ba[i], 1'b0, 1'b1);
      rd(8'h34, rv);
      chk({rv[3:0], ivf}, 5'h9);
      expect_bytes(0, 0, 1'b0, 0);
      wr(8'h34, 32'h7f);
    end
    wr(8'h08, 32'h2);
    run(0, 128, 0, 1'b0, 1'b0);
    wr(8'h00, 32'h5);
    repeat (2) @(posedge i_clock);
    #1 chk({cef, paf}, 2'b11);
    for (int n = 0; n < 9000 && !done; n++) @(posedge i_clock);
    expect_bytes(0, 128, 1'b0, 0);
    rd(8'h34, rv);
    chk(rv, 32'h3);
    wr(8'h34, 32'h7f);
    hold <= 1'b1;
    run(0, 2, 0, 1'b0, 1'b1);
    chk({pef, busy, done, paf}, 4'b1000);
    rd(8'h34, rv);
    chk(rv, 32'h8);
    expect_bytes(0, 0, 1'b0, 0);
    hold <= 1'b0;
    wr(8'h34, 32'h7f);
    wr(8'h18, 32'd10);
    wr(8'h1c, 32'd3);
    wr(8'h00, 32'h4);
    repeat (4) @(posedge i_clock);
    rd(8'h34, rv);
    chk(rv, 32'h40);
    for (int a = 10; a < 13; a++)
    begin
      wr(8'h2c, a);
      rd(8'h30, rv);
      chk(rv, a < 12 ? {mem[a][7:0], mem[a][15:8]} : mem[a]);
    end
    wr(8'h20, 32'd50);
    lit("\"A$\"$0D$$\"", 8'd4, 16'h0);
    wr(8'h2c, 32'd50);
    rd(8'h30, rv);
    chk(rv, 32'h4122);
    wr(8'h2c, 32'd51);
    rd(8'h30, rv);
    chk(rv, 32'h0d24);
    lit("\"\"", 8'd0, 16'h0);
    lit("A", 8'd0, 16'h1f3);
    give_verdict();
  end
endmodule // msp_printer_test
